// ---- asf_pkg.sv ----
/*
 * Constants shared by the audio serial status block: register offsets,
 * bit positions, reset values and FIFO geometry.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
package asf_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_IRQ_EN = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_TX_DATA = 8'h10;
    localparam logic [7:0] OFS_RX_DATA = 8'h14;

    ////////////////////////////////////////////////////////////////////////
    // Status register field positions
    localparam int TX_CNT_LSB = 28;
    localparam int RX_CNT_LSB = 24;
    localparam int BIT_LEFT_ZERO_CROSS_FLAG = 23;
    localparam int BIT_RIGHT_ZERO_CROSS_FLAG = 22;
    localparam int BIT_TX_BUSY = 21;
    localparam int BIT_TX_EMPTY = 20;
    localparam int BIT_TX_FULL = 19;
    localparam int BIT_TX_THF = 18;
    localparam int BIT_RX_EMPTY = 12;
    localparam int BIT_RX_FULL = 11;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt enable and control field positions
    localparam int BIT_LZC_IE = 12;
    localparam int BIT_RZC_IE = 11;
    localparam int BIT_TX_THRESHOLD_LEVEL_IE = 10;
    localparam int TX_TH_LSB = 0;
    localparam int TX_TH_W = 3;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and geometry
    localparam logic [31:0] STATUS_RESET = 32'h0014_1000;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] IRQ_EN_RESET = 32'h0000_0000;
    localparam int FIFO_DEPTH = 8;
    localparam int CNT_W = 4;
    localparam int PTR_W = 3;
    localparam int FRAME_BITS = 32;
    localparam logic [4:0] FRAME_LAST = 5'h1F;
    localparam int CHAN_W = 16;

endpackage : asf_pkg

// ---- asf_sync.sv ----
/*
 * Two-stage synchroniser for a bundle of independent levels.
 * Assumes each bit is a level or a toggle that holds for several
 * destination clocks; multi-bit words must not pass through here.
 */
`timescale 1ns/1ps

module asf_sync #(
    parameter int WIDTH = 1
) (
    // Destination clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            stage1 <= '0;
            o_sync <= '0;
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end

endmodule : asf_sync

// ---- asf_audio_status.sv ----
/*
 * Audio serial port with transmit and receive FIFOs and its status
 * register, reached over an Avalon-MM slave with waitrequest.
 * Assumes the codec drives the bit clock and the word select; the bit
 * clock is a separate domain and may stop between frames.
 */
`timescale 1ns/1ps

// Behaviour
// - The top nibble of the status register shows the transmit FIFO word count, 0 to 8.
// - The next nibble down shows the receive FIFO word count, 0 to 8.
// - Bit 23 sets when the next left sample changes sign or is all zero.
// - Bit 22 sets when the next right sample changes sign or is all zero.
// - Writing one to bit 23 or bit 22 clears that zero-cross flag.
// - Bit 21 clears only once FIFO and shift register have all been shifted out.
// - Bit 21 sets as soon as the first word moves from the FIFO to the shift buffer stage.
// - Bit 20 is high exactly when the transmit count is zero.
// - Bit 19 is high exactly when the transmit FIFO holds eight words.
// - Bit 18 sets whenever the transmit count is at or below the threshold.
// - Bit 18 stays high until data writes lift the count above the threshold or a control write lowers the threshold below it.
// - Bits 21, 20 and 19 ignore software writes.
// - A zero-cross flag with its enable set raises the interrupt output.
// - The threshold flag with its enable set raises the interrupt output.
module asf_audio_status #(
    parameter int ADDR_W = 8,
    parameter int DEPTH = asf_pkg::FIFO_DEPTH
) (
    // System clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    // Serial audio link
    input wire logic i_bclk,
    input wire logic i_lrclk,
    input wire logic i_sdi,
    output logic o_sdo,
    // Interrupt
    output logic o_irq
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [31:0] tx_mem [DEPTH];
    logic [31:0] rx_mem [DEPTH];
    logic [asf_pkg::PTR_W-1:0] tx_wptr, tx_rptr, rx_wptr, rx_rptr;
    logic [asf_pkg::CNT_W-1:0] tx_fill_count, rx_fill_count;
    logic [asf_pkg::TX_TH_W-1:0] tx_threshold_level;
    logic left_zero_cross_irq_en, right_zero_cross_irq_en, tx_threshold_irq_en;
    logic left_zero_cross_flag, right_zero_cross_flag;
    logic tx_shifter_active, tx_fifo_empty_flag, tx_fifo_full_flag, tx_threshold_flag;
    logic rx_empty_flag, rx_full_flag;
    logic [31:0] stage_word;
    logic stage_full, in_flight;
    logic [asf_pkg::CHAN_W-1:0] prev_left, prev_right;
    // Crossing state
    logic take_tgl, rx_tgl, link_active;
    logic take_s, take_d, rx_s, rx_d, active_s, active_d;
    logic [31:0] rx_hold;
    // Link side
    logic lr_s, sdi_s, lr_d;
    logic [31:0] tx_sh, rx_sh;
    logic [4:0] bit_cnt;
    logic frame_on;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    wire bus_req = i_read | i_write;
    wire bus_done = bus_req & ~o_waitrequest;
    wire wr_done = bus_done & i_write;
    wire rd_done = bus_done & i_read;
    wire sel_control = (i_address == asf_pkg::OFS_CONTROL[ADDR_W-1:0]);
    wire sel_irq_en = (i_address == asf_pkg::OFS_IRQ_EN[ADDR_W-1:0]);
    wire sel_status = (i_address == asf_pkg::OFS_STATUS[ADDR_W-1:0]);
    wire sel_tx_data = (i_address == asf_pkg::OFS_TX_DATA[ADDR_W-1:0]);
    wire sel_rx_data = (i_address == asf_pkg::OFS_RX_DATA[ADDR_W-1:0]);

    wire [31:0] status_word = {
        tx_fill_count, rx_fill_count,
        left_zero_cross_flag, right_zero_cross_flag,
        tx_shifter_active, tx_fifo_empty_flag,
        tx_fifo_full_flag, tx_threshold_flag,
        5'h00, rx_empty_flag, rx_full_flag, 11'h000};
    wire [31:0] control_word = {29'h0000_0000, tx_threshold_level};
    wire [31:0] irq_en_word = {19'h0_0000, left_zero_cross_irq_en,
        right_zero_cross_irq_en, tx_threshold_irq_en, 10'h000};
    wire [31:0] read_mux = sel_status ? status_word :
        sel_control ? control_word :
        sel_irq_en ? irq_en_word :
        sel_rx_data ? rx_mem[rx_rptr] : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Avalon slave: one wait cycle, then completion
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_waitrequest <= 1'b1;
            o_readdata <= 32'h0000_0000;
        end else begin
            o_waitrequest <= ~(bus_req & o_waitrequest);
            if (bus_req & o_waitrequest) begin
                o_readdata <= read_mux;
            end
        end
    end

    // Control and enable registers
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_threshold_level <= asf_pkg::CONTROL_RESET[asf_pkg::TX_TH_W-1:0];
            left_zero_cross_irq_en <= asf_pkg::IRQ_EN_RESET[asf_pkg::BIT_LZC_IE];
            right_zero_cross_irq_en <= asf_pkg::IRQ_EN_RESET[asf_pkg::BIT_RZC_IE];
            tx_threshold_irq_en <= asf_pkg::IRQ_EN_RESET[asf_pkg::BIT_TX_THRESHOLD_LEVEL_IE];
        end else begin
            if (wr_done & sel_control) begin
                tx_threshold_level <= i_writedata[asf_pkg::TX_TH_LSB +: asf_pkg::TX_TH_W];
            end
            if (wr_done & sel_irq_en) begin
                left_zero_cross_irq_en <= i_writedata[asf_pkg::BIT_LZC_IE];
                right_zero_cross_irq_en <= i_writedata[asf_pkg::BIT_RZC_IE];
                tx_threshold_irq_en <= i_writedata[asf_pkg::BIT_TX_THRESHOLD_LEVEL_IE];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit FIFO
    wire tx_push = wr_done & sel_tx_data & (tx_fill_count != DEPTH[asf_pkg::CNT_W-1:0]);
    wire tx_pop = ~stage_full & (tx_fill_count != 4'h0);
    wire [asf_pkg::CNT_W-1:0] next_tx_fill_count =
        tx_fill_count + {3'h0, tx_push} - {3'h0, tx_pop};
    wire [31:0] head_word = tx_mem[tx_rptr];

    always_ff @(posedge i_mclk) begin
        if (tx_push) begin
            tx_mem[tx_wptr] <= i_writedata;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_wptr <= 3'h0;
            tx_rptr <= 3'h0;
            tx_fill_count <= 4'h0;
        end else begin
            tx_wptr <= tx_wptr + {2'h0, tx_push};
            tx_rptr <= tx_rptr + {2'h0, tx_pop};
            tx_fill_count <= next_tx_fill_count;
        end
    end

    // Flags follow the count; bus writes never reach them
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_fifo_empty_flag <= asf_pkg::STATUS_RESET[asf_pkg::BIT_TX_EMPTY];
            tx_fifo_full_flag <= asf_pkg::STATUS_RESET[asf_pkg::BIT_TX_FULL];
            tx_threshold_flag <= asf_pkg::STATUS_RESET[asf_pkg::BIT_TX_THF];
        end else begin
            tx_fifo_empty_flag <= (next_tx_fill_count == 4'h0);
            tx_fifo_full_flag <= (next_tx_fill_count == DEPTH[asf_pkg::CNT_W-1:0]);
            tx_threshold_flag <= (next_tx_fill_count <= {1'b0, tx_threshold_level});
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shift buffer stage and zero-cross detection
    wire [asf_pkg::CHAN_W-1:0] new_left = head_word[31:16];
    wire [asf_pkg::CHAN_W-1:0] new_right = head_word[15:0];
    wire left_zc = tx_pop & ((new_left[15] ^ prev_left[15]) | (new_left == 16'h0000));
    wire right_zc = tx_pop & ((new_right[15] ^ prev_right[15]) | (new_right == 16'h0000));
    wire clr_left = wr_done & sel_status & i_writedata[asf_pkg::BIT_LEFT_ZERO_CROSS_FLAG];
    wire clr_right = wr_done & sel_status & i_writedata[asf_pkg::BIT_RIGHT_ZERO_CROSS_FLAG];
    wire take_evt = take_s ^ take_d;
    wire active_fall = active_d & ~active_s;

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            stage_word <= 32'h0000_0000;
            stage_full <= 1'b0;
            prev_left <= 16'h0000;
            prev_right <= 16'h0000;
        end else begin
            if (tx_pop) begin
                stage_word <= head_word;
                prev_left <= new_left;
                prev_right <= new_right;
            end
            stage_full <= tx_pop | (stage_full & ~take_evt);
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            left_zero_cross_flag <= asf_pkg::STATUS_RESET[asf_pkg::BIT_LEFT_ZERO_CROSS_FLAG];
            right_zero_cross_flag <= asf_pkg::STATUS_RESET[asf_pkg::BIT_RIGHT_ZERO_CROSS_FLAG];
        end else begin
            left_zero_cross_flag <= left_zc | (left_zero_cross_flag & ~clr_left);
            right_zero_cross_flag <= right_zc | (right_zero_cross_flag & ~clr_right);
        end
    end

    // Busy spans stage, word in flight on the link and FIFO contents
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            in_flight <= 1'b0;
            tx_shifter_active <= asf_pkg::STATUS_RESET[asf_pkg::BIT_TX_BUSY];
        end else begin
            in_flight <= take_evt | (in_flight & ~active_fall);
            if (tx_pop) begin
                tx_shifter_active <= 1'b1;
            end else if (~stage_full & ~in_flight & (tx_fill_count == 4'h0)) begin
                tx_shifter_active <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive FIFO
    wire rx_evt = rx_s ^ rx_d;
    wire rx_push = rx_evt & (rx_fill_count != DEPTH[asf_pkg::CNT_W-1:0]);
    wire rx_pop = rd_done & sel_rx_data & (rx_fill_count != 4'h0);
    wire [asf_pkg::CNT_W-1:0] next_rx_fill_count =
        rx_fill_count + {3'h0, rx_push} - {3'h0, rx_pop};

    always_ff @(posedge i_mclk) begin
        if (rx_push) begin
            rx_mem[rx_wptr] <= rx_hold;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_wptr <= 3'h0;
            rx_rptr <= 3'h0;
            rx_fill_count <= 4'h0;
            rx_empty_flag <= asf_pkg::STATUS_RESET[asf_pkg::BIT_RX_EMPTY];
            rx_full_flag <= asf_pkg::STATUS_RESET[asf_pkg::BIT_RX_FULL];
        end else begin
            rx_wptr <= rx_wptr + {2'h0, rx_push};
            rx_rptr <= rx_rptr + {2'h0, rx_pop};
            rx_fill_count <= next_rx_fill_count;
            rx_empty_flag <= (next_rx_fill_count == 4'h0);
            rx_full_flag <= (next_rx_fill_count == DEPTH[asf_pkg::CNT_W-1:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt output
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= (left_zero_cross_flag & left_zero_cross_irq_en) |
                (right_zero_cross_flag & right_zero_cross_irq_en) |
                (tx_threshold_flag & tx_threshold_irq_en);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Crossings into the system clock
    logic stage_full_s;

    asf_sync #(.WIDTH(3)) u_to_mclk (
        .i_clk(i_mclk),
        .i_nrst(i_nrst),
        .i_async({take_tgl, rx_tgl, link_active}),
        .o_sync({take_s, rx_s, active_s})
    );

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            take_d <= 1'b0;
            rx_d <= 1'b0;
            active_d <= 1'b0;
        end else begin
            take_d <= take_s;
            rx_d <= rx_s;
            active_d <= active_s;
        end
    end

    // Crossings into the bit clock, pins included
    asf_sync #(.WIDTH(3)) u_to_bclk (
        .i_clk(i_bclk),
        .i_nrst(i_nrst),
        .i_async({stage_full, i_lrclk, i_sdi}),
        .o_sync({stage_full_s, lr_s, sdi_s})
    );

    ////////////////////////////////////////////////////////////////////////
    // Link side: left word starts when word select falls
    wire frame_start = lr_d & ~lr_s;
    wire frame_end = frame_on & (bit_cnt == asf_pkg::FRAME_LAST);

    always_ff @(posedge i_bclk or negedge i_nrst) begin
        if (!i_nrst) begin
            lr_d <= 1'b0;
            frame_on <= 1'b0;
            bit_cnt <= 5'h00;
            take_tgl <= 1'b0;
            link_active <= 1'b0;
        end else begin
            lr_d <= lr_s;
            if (frame_start) begin
                frame_on <= 1'b1;
                bit_cnt <= 5'h00;
                take_tgl <= take_tgl ^ stage_full_s;
                link_active <= stage_full_s;
            end else if (frame_on) begin
                bit_cnt <= bit_cnt + 5'h01;
                frame_on <= ~frame_end;
                link_active <= link_active & ~frame_end;
            end
        end
    end

    // Transmit and receive shifters
    always_ff @(posedge i_bclk or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_sh <= 32'h0000_0000;
            rx_sh <= 32'h0000_0000;
            o_sdo <= 1'b0;
        end else begin
            if (frame_start) begin
                tx_sh <= stage_full_s ? stage_word : 32'h0000_0000;
            end else if (frame_on) begin
                o_sdo <= tx_sh[31];
                tx_sh <= {tx_sh[30:0], 1'b0};
                rx_sh <= {rx_sh[30:0], sdi_s};
            end else begin
                o_sdo <= 1'b0;
            end
        end
    end

    // Received word is held stable until the next frame completes
    always_ff @(posedge i_bclk or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_hold <= 32'h0000_0000;
            rx_tgl <= 1'b0;
        end else if (frame_end) begin
            rx_hold <= {rx_sh[30:0], sdi_s};
            rx_tgl <= ~rx_tgl;
        end
    end

endmodule : asf_audio_status

// ---- asf_status_checker.sv ----
/*
 * Bus handshake and status field checks for the audio serial status block.
 * Assumes binding onto asf_audio_status; sees only its bus-side ports.
 */
`timescale 1ns/1ps

module asf_status_checker #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] o_readdata,
    input wire logic o_waitrequest
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_nrst);

    wire req = i_read | i_write;
    wire st_rd = i_read & ~o_waitrequest & (i_address == ADDR_W'(asf_pkg::OFS_STATUS));

    ////////////////////////////////////////////////////////////////////////
    sequence s_req_start;
        $rose(req) && o_waitrequest;
    endsequence
    sequence s_answer;
        !o_waitrequest ##1 o_waitrequest;
    endsequence

    property p_wait_answer;
        s_req_start |=> s_answer;
    endproperty
    property p_wait_idle;
        !req |-> o_waitrequest;
    endproperty
    property p_wait_req;
        !o_waitrequest |-> req;
    endproperty
    property p_readdata_hold;
        !req && !$past(req) |-> $stable(o_readdata);
    endproperty
    property p_tx_cnt;
        st_rd |-> o_readdata[31:28] <= 4'h8;
    endproperty
    property p_rx_cnt;
        st_rd |-> o_readdata[27:24] <= 4'h8;
    endproperty
    property p_empty;
        st_rd |-> o_readdata[20] == (o_readdata[31:28] == 4'h0);
    endproperty
    property p_full;
        st_rd |-> o_readdata[19] == (o_readdata[31:28] == 4'h8);
    endproperty
    property p_busy;
        st_rd && (o_readdata[31:28] != 4'h0) |-> o_readdata[21];
    endproperty

    ////////////////////////////////////////////////////////////////////////
    a_wait_answer: assert property (p_wait_answer)
        else $error("waitrequest did not drop for exactly one cycle");
    a_wait_idle: assert property (p_wait_idle)
        else $error("waitrequest low with no request");
    a_wait_req: assert property (p_wait_req)
        else $error("answer given without a request");
    a_readdata_hold: assert property (p_readdata_hold)
        else $error("readdata changed between accesses");
    a_tx_cnt: assert property (p_tx_cnt)
        else $error("transmit count above eight");
    a_rx_cnt: assert property (p_rx_cnt)
        else $error("receive count above eight");
    a_empty: assert property (p_empty)
        else $error("empty flag disagrees with transmit count");
    a_full: assert property (p_full)
        else $error("full flag disagrees with transmit count");
    a_busy: assert property (p_busy)
        else $error("shifter idle while words wait");

endmodule : asf_status_checker

// ---- asf_codec_model.sv ----
/*
 * Behavioural codec on the serial audio link: makes bit clock bursts,
 * word select and a toggling data line, and captures the serial output.
 * Assumes the bench calls frame() between bus accesses.
 */
`timescale 1ns/1ps

module asf_codec_model (
    // Serial data from the port
    input wire logic i_sdo,
    // Link toward the port
    output logic o_bclk,
    output logic o_lrclk,
    output logic o_sdi,
    // Capture of the last burst
    output logic [43:0] o_window
);
    initial begin
        o_bclk = 1'b0;
        o_lrclk = 1'b1;
        o_sdi = 1'b0;
        o_window = '0;
    end

    // Bit clock runs only inside a burst; word select low for bits 4 to 23
    task automatic frame(input int n);
        int i;
        o_window = '0;
        #3.3;
        for (i = 0; i < n; i++) begin
            o_lrclk = !(i >= 4 && i < 24);
            o_sdi = ~o_sdi;
            #7.5;
            o_window = {o_window[42:0], i_sdo};
            o_bclk = 1'b1;
            #7.5;
            o_bclk = 1'b0;
        end
    endtask : frame

endmodule : asf_codec_model

// ---- asf_audio_status_tb_top.sv ----
/*
 * Self-checking bench for asf_audio_status: register tasks over Avalon-MM
 * and link bursts from the codec model.
 * Assumes asf_pkg, the design and the codec model are compiled first.
 */
`timescale 1ns/1ps

module asf_audio_status_tb_top;
    localparam int ADDR_W = 8;
    localparam logic [31:0] M = 32'hFFFC_0000;
    localparam logic [31:0] MZ = 32'hFF3C_0000;

    logic i_mclk = 1'b0;
    logic i_nrst, i_read, i_write, o_waitrequest, i_bclk, i_lrclk, i_sdi, o_sdo, o_irq;
    logic [ADDR_W-1:0] i_address;
    logic [31:0] i_writedata, o_readdata, rd;
    logic [31:0] w [10];
    logic [43:0] window;
    int error_cnt = 0;
    int checked = 0;

    always #10 i_mclk = ~i_mclk;

    asf_audio_status #(.ADDR_W(ADDR_W)) DUT (
        .i_mclk(i_mclk), .i_nrst(i_nrst), .i_address(i_address), .i_read(i_read),
        .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata),
        .o_waitrequest(o_waitrequest), .i_bclk(i_bclk), .i_lrclk(i_lrclk),
        .i_sdi(i_sdi), .o_sdo(o_sdo), .o_irq(o_irq)
    );

    asf_codec_model u_codec (
        .i_sdo(o_sdo), .o_bclk(i_bclk), .o_lrclk(i_lrclk), .o_sdi(i_sdi), .o_window(window)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One access; held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_mclk);
        i_address <= ADDR_W'(a);
        i_write <= wr;
        i_read <= !wr;
        i_writedata <= d;
        @(posedge i_mclk);
        while (o_waitrequest !== 1'b0) begin
            n++;
            if (n > 50) begin
                error_cnt++;
                conclude();
            end
            @(posedge i_mclk);
        end
        rd = o_readdata;
        i_read <= 1'b0;
        i_write <= 1'b0;
    endtask : bus

    task automatic rs(input logic [31:0] exp, input logic [31:0] mask);
        bus(1'b0, asf_pkg::OFS_STATUS, 32'h0000_0000);
        chk(rd & mask, exp);
    endtask : rs

    task automatic sdo_chk(input logic [31:0] exp);
        logic f;
        f = 1'b0;
        for (int k = 0; k <= 12; k++) begin
            if (window[k +: 32] === exp) begin
                f = 1'b1;
            end
        end
        chk({31'h0, f}, 32'h0000_0001);
    endtask : sdo_chk

    ////////////////////////////////////////////////////////////////////////
    initial begin
        i_nrst = 1'b0;
        i_read = 1'b0;
        i_write = 1'b0;
        i_address = '0;
        i_writedata = '0;
        w[0] = 32'h8000_0001;
        w[1] = 32'h8001_0000;
        for (int i = 2; i < 10; i++) begin
            w[i] = 32'h4000_0000 + 32'(i);
        end
        fork
            u_codec.frame(4);
            repeat (4) @(posedge i_mclk);
        join
        i_nrst <= 1'b1;
        rs(asf_pkg::STATUS_RESET, 32'hFFFF_FFFF);
        bus(1'b1, asf_pkg::OFS_CONTROL, 32'h0000_0003);
        bus(1'b0, asf_pkg::OFS_CONTROL, 32'h0000_0000);
        chk(rd, 32'h0000_0003);
        bus(1'b1, asf_pkg::OFS_IRQ_EN, 32'h0000_1000);
        for (int i = 0; i < 9; i++) begin
            bus(1'b1, asf_pkg::OFS_TX_DATA, w[i]);
        end
        repeat (4) @(posedge i_mclk);
        rs(32'h80A8_0000, M);
        chk({31'h0, o_irq}, 32'h0000_0001);
        // Overfill and write ones to the read-only flags
        bus(1'b1, asf_pkg::OFS_TX_DATA, 32'h7777_7777);
        bus(1'b1, asf_pkg::OFS_STATUS, 32'h003C_0000);
        rs(32'h80A8_0000, M);
        bus(1'b1, asf_pkg::OFS_STATUS, 32'h00C0_0000);
        rs(32'h8028_0000, M);
        repeat (2) @(posedge i_mclk);
        chk({31'h0, o_irq}, 32'h0000_0000);
        for (int f = 0; f < 10; f++) begin
            u_codec.frame(44);
            repeat (10) @(posedge i_mclk);
            sdo_chk(w[f]);
            if (f == 0) begin
                rs(32'h7160_0000, M);
                chk({31'h0, o_irq}, 32'h0000_0000);
                bus(1'b1, asf_pkg::OFS_IRQ_EN, 32'h0000_0800);
                repeat (2) @(posedge i_mclk);
                chk({31'h0, o_irq}, 32'h0000_0001);
            end
            if (f == 4) begin
                rs(32'h3524_0000, MZ);
                bus(1'b1, asf_pkg::OFS_IRQ_EN, 32'h0000_0400);
                repeat (2) @(posedge i_mclk);
                chk({31'h0, o_irq}, 32'h0000_0001);
                bus(1'b1, asf_pkg::OFS_TX_DATA, w[9]);
                rs(32'h4520_0000, MZ);
                repeat (2) @(posedge i_mclk);
                chk({31'h0, o_irq}, 32'h0000_0000);
            end
            if (f == 8) begin
                rs(32'h0834_0000, MZ);
            end
        end
        rs(32'h0814_0000, MZ);
        u_codec.frame(44);
        repeat (10) @(posedge i_mclk);
        sdo_chk(32'h0000_0000);
        rs(32'h0814_0000, MZ);
        conclude();
    end

    initial begin
        #200_000;
        error_cnt++;
        conclude();
    end

endmodule : asf_audio_status_tb_top

bind asf_audio_status asf_status_checker #(.ADDR_W(ADDR_W)) u_chk (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest)
);
